// File: logic/psw_defines.svh
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH
// command codes
`define PSW_CMD_WORD      8'h79
`define PSW_CMD_VOUT      8'h7A
`define PSW_CMD_IOUT      8'h7B
`define PSW_CMD_MASK      8'h1B
// reset values
`define PSW_VOUT_RST      8'h00
`define PSW_IOUT_RST      8'h00
`define PSW_VOUT_MASK_RST 8'h00
`define PSW_IOUT_MASK_RST 8'h00
`define PSW_PG_MASK_RST   1'b1
// implemented flag bits
`define PSW_VOUT_LIVE     8'hFC
`define PSW_IOUT_LIVE     8'hA0
// low byte fields
`define PSW_LO_OFF        6
`define PSW_LO_OVF        5
`define PSW_LO_OCF        4
`define PSW_LO_TEMP       2
`define PSW_LO_CML        1
`define PSW_LO_OTH        0
// high byte fields (bit within the high byte)
`define PSW_HI_VFW        7
`define PSW_HI_CURRENT_SUMMARY       6
`define PSW_HI_INPUT      5
`define PSW_HI_MFR        4
`define PSW_HI_PGZ        3
// detail byte fields
`define PSW_VO_OVF        7
`define PSW_VO_OVW        6
`define PSW_VO_UVW        5
`define PSW_VO_UVF        4
`define PSW_VO_LIM        3
`define PSW_VO_TON        2
`define PSW_IO_OCF        7
`define PSW_IO_OCW        5
`define PSW_IN_LOWVIN     3
`define PSW_MF_OTFBG      7
`define PSW_MF_ADDRFAIL   4
`endif

// File: logic/psw_pkg.sv
package psw_pkg;
	// output-voltage events, one cycle or level, ordered as the flag byte
	typedef struct packed {
		logic overvoltage_fault_flag;
		logic overvoltage_warning_flag;
		logic undervoltage_warning_flag;
		logic undervoltage_fault_flag;
		logic setpoint_limit_warning;
		logic turn_on_timeout_fault;
	} psw_vout_evt_t;
	typedef struct packed {
		logic overcurrent_fault_flag;
		logic overcurrent_warning_flag;
	} psw_iout_evt_t;
	typedef enum logic [0:0] {
		PSW_PG_WAIT  = 1'b0,
		PSW_PG_ARMED = 1'b1
	} psw_pg_state_t;
endpackage

// File: logic/psw_flag_bank.sv
`timescale 1ns/1ps
`include "psw_defines.svh"
module psw_flag_bank #(
	parameter int         W    = 8,
	parameter logic [7:0] LIVE = 8'hFF,
	parameter logic [7:0] RST  = 8'h00
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	input  wire logic         force_zero_i,
	output logic      [W-1:0] flags_o
);
	// live and reset masks are byte-wide, so no other width can be served
	if (W != 8) begin : g_bad_width
		$error("psw_flag_bank serves byte-wide banks only");
	end
	for (genvar b = 0; b < W; b++) begin : g_bit
		if (LIVE[b]) begin : g_live
			logic flag_q;
			always_ff @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					flag_q <= RST[b];
				end else if (ce_i) begin
					// set beats clear so an event in the clear cycle survives
					if (force_zero_i) begin
						flag_q <= 1'b0;
					end else if (set_i[b]) begin
						flag_q <= 1'b1;
					end else if (clr_i[b]) begin
						flag_q <= 1'b0;
					end
				end
			end
			assign flags_o[b] = flag_q;
		end else begin : g_fixed
			assign flags_o[b] = 1'b0;
		end
	end
endmodule // psw_flag_bank

// File: logic/psw_pg_gate.sv
`timescale 1ns/1ps
module psw_pg_gate (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic power_good_i,
	input  wire logic mask_i,
	output logic      armed_o,
	output logic      alert_o
);
	psw_pkg::psw_pg_state_t state_q;
	// stays in wait until power is good once, so an unstarted rail holds no alert
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= psw_pkg::PSW_PG_WAIT;
		end else if (ce_i) begin
			case (state_q)
				psw_pkg::PSW_PG_WAIT: begin
					if (power_good_i) state_q <= psw_pkg::PSW_PG_ARMED;
				end
				psw_pkg::PSW_PG_ARMED: state_q <= psw_pkg::PSW_PG_ARMED;
				default: state_q <= psw_pkg::PSW_PG_WAIT;
			endcase
		end
	end
	assign armed_o = (state_q == psw_pkg::PSW_PG_ARMED);
	assign alert_o = armed_o && !mask_i && !power_good_i;
endmodule // psw_pg_gate

// File: logic/psw_status.sv
`timescale 1ns/1ps
`include "psw_defines.svh"
// Notes on behaviour
// - status word read: low byte is status byte summary, high byte summary bits
// - low byte bit 6 reads 1 while the converter is not enabled
// - high bit 7 is the OR of the six output-voltage flags
// - high bit 6 is the OR of overcurrent fault and warning flags
// - high bit 5 reads 1 while any input status flag is set
// - high bit 4 reads 1 on bandgap over-temperature or address-pin failure
// - summary bits ignore writes, clear only when their detail flags clear
// - high bit 3 reads 1 when power is not good, from the listed causes
// - power-not-good flag is live, never latched
// - power-not-good alert mask resets to 1
// - unmasked power-not-good alert held off until power first goes good
// - voltage bit 7 sets above the overvoltage fault limit
// - voltage bit 6 sets above the overvoltage warning limit
// - voltage bit 5 sets below the undervoltage warning limit
// - voltage bit 4 sets below the undervoltage fault limit
// - voltage bit 3 on out-of-range setpoint request, bit 2 on turn-on timeout
// - voltage and current flags clear by write and each has an alert mask
// - loop slave holds every output-voltage flag at 0
// - current bit 7 on overcurrent fault, bit 5 on warning, others 0
// - low byte bit 0 reads 1 after power-up through the low-input flag
module psw_status (
	input  wire logic                  mclk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	// command port
	input  wire logic [7:0]            cmd_i,
	input  wire logic                  rd_i,
	input  wire logic                  wr_i,
	input  wire logic [15:0]           wdata_i,
	output logic      [15:0]           rdata_o,
	output logic                       rvalid_o,
	output logic                       nack_o,
	// converter state
	input  wire logic                  enable_i,
	input  wire logic                  loop_slave_i,
	input  wire psw_pkg::psw_vout_evt_t vout_evt_i,
	input  wire psw_pkg::psw_iout_evt_t iout_evt_i,
	input  wire psw_pkg::psw_vout_evt_t vout_cond_i,
	input  wire psw_pkg::psw_iout_evt_t iout_cond_i,
	input  wire logic                  temp_cond_i,
	input  wire logic                  low_vin_cond_i,
	// other status bytes
	input  wire logic [7:0]            input_flags_i,
	input  wire logic [7:0]            temp_flags_i,
	input  wire logic [7:0]            cml_flags_i,
	input  wire logic [7:0]            mfr_flags_i,
	input  wire logic                  ext_alert_i,
	output logic                       alert_o
);
	logic [7:0]  vout_flags;
	logic [7:0]  iout_flags;
	logic [7:0]  vout_set;
	logic [7:0]  iout_set;
	logic [7:0]  vout_clr;
	logic [7:0]  iout_clr;
	logic [7:0]  vout_mask_q;
	logic [7:0]  iout_mask_q;
	logic        pg_mask_q;
	logic        power_not_good;
	logic        power_good;
	logic        pg_armed;
	logic        pg_alert;
	logic [7:0]  word_lo;
	logic [7:0]  word_hi;
	logic [15:0] status_word;
	logic [15:0] rdata_q;
	logic        rvalid_q;
	logic        nack_q;
	logic        mapped;
	logic        wr_vout;
	logic        wr_iout;
	logic        wr_mask;

	////////////////////////////////////////////////////////////////////////////
	// detail flag bytes

	always_comb begin
		vout_set = 8'h00;
		vout_set[`PSW_VO_OVF] = vout_evt_i.overvoltage_fault_flag;
		vout_set[`PSW_VO_OVW] = vout_evt_i.overvoltage_warning_flag;
		vout_set[`PSW_VO_UVW] = vout_evt_i.undervoltage_warning_flag;
		vout_set[`PSW_VO_UVF] = vout_evt_i.undervoltage_fault_flag;
		vout_set[`PSW_VO_LIM] = vout_evt_i.setpoint_limit_warning;
		vout_set[`PSW_VO_TON] = vout_evt_i.turn_on_timeout_fault;
		iout_set = 8'h00;
		iout_set[`PSW_IO_OCF] = iout_evt_i.overcurrent_fault_flag;
		iout_set[`PSW_IO_OCW] = iout_evt_i.overcurrent_warning_flag;
	end

	assign wr_vout = wr_i && (cmd_i == `PSW_CMD_VOUT);
	assign wr_iout = wr_i && (cmd_i == `PSW_CMD_IOUT);
	assign wr_mask = wr_i && (cmd_i == `PSW_CMD_MASK);
	assign vout_clr = wr_vout ? wdata_i[7:0] : 8'h00;
	assign iout_clr = wr_iout ? wdata_i[7:0] : 8'h00;

	psw_flag_bank #(
		.W    (8),
		.LIVE (`PSW_VOUT_LIVE),
		.RST  (`PSW_VOUT_RST)
	) u_vout (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.set_i        (vout_set),
		.clr_i        (vout_clr),
		.force_zero_i (loop_slave_i),
		.flags_o      (vout_flags)
	);

	psw_flag_bank #(
		.W    (8),
		.LIVE (`PSW_IOUT_LIVE),
		.RST  (`PSW_IOUT_RST)
	) u_iout (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.set_i        (iout_set),
		.clr_i        (iout_clr),
		.force_zero_i (1'b0),
		.flags_o      (iout_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	// alert masks; nonvolatile copy lives elsewhere, these hold the working value

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			vout_mask_q <= `PSW_VOUT_MASK_RST;
			iout_mask_q <= `PSW_IOUT_MASK_RST;
		end else if (ce_i && wr_mask) begin
			if (wdata_i[7:0] == `PSW_CMD_VOUT) vout_mask_q <= wdata_i[15:8];
			if (wdata_i[7:0] == `PSW_CMD_IOUT) iout_mask_q <= wdata_i[15:8];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pg_mask_q <= `PSW_PG_MASK_RST;
		end else if (ce_i && wr_mask && wdata_i[7:0] == `PSW_CMD_WORD) begin
			pg_mask_q <= wdata_i[8+`PSW_HI_PGZ];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power good

	// live causes of power not good
	// a converter that is not enabled never counts as good
	assign power_not_good = !enable_i | vout_cond_i.overvoltage_fault_flag
		| vout_cond_i.overvoltage_warning_flag
		| vout_cond_i.undervoltage_warning_flag
		| vout_cond_i.undervoltage_fault_flag
		| vout_cond_i.turn_on_timeout_fault
		| (|iout_cond_i) | temp_cond_i | low_vin_cond_i;
	assign power_good = !power_not_good;

	psw_pg_gate u_pg (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.power_good_i (power_good),
		.mask_i       (pg_mask_q),
		.armed_o      (pg_armed),
		.alert_o      (pg_alert)
	);

	////////////////////////////////////////////////////////////////////////////
	// summary word, built from detail flags, enable_i and the live power-good causes, so writes cannot touch it

	always_comb begin
		word_lo = 8'h00;
		word_lo[`PSW_LO_OFF]  = !enable_i;
		word_lo[`PSW_LO_OVF]  = vout_flags[`PSW_VO_OVF];
		word_lo[`PSW_LO_OCF]  = iout_flags[`PSW_IO_OCF];
		word_lo[`PSW_LO_TEMP] = |temp_flags_i;
		word_lo[`PSW_LO_CML]  = |cml_flags_i;
		word_lo[`PSW_LO_OTH]  = vout_flags[`PSW_VO_OVW] | vout_flags[`PSW_VO_UVW]
			| vout_flags[`PSW_VO_UVF] | vout_flags[`PSW_VO_LIM]
			| vout_flags[`PSW_VO_TON] | iout_flags[`PSW_IO_OCW]
			| input_flags_i[`PSW_IN_LOWVIN] | mfr_flags_i[`PSW_MF_OTFBG]
			| mfr_flags_i[`PSW_MF_ADDRFAIL];
		word_hi = 8'h00;
		word_hi[`PSW_HI_VFW]   = |vout_flags;
		word_hi[`PSW_HI_CURRENT_SUMMARY]  = |iout_flags;
		word_hi[`PSW_HI_INPUT] = |input_flags_i;
		word_hi[`PSW_HI_MFR]   = mfr_flags_i[`PSW_MF_OTFBG] | mfr_flags_i[`PSW_MF_ADDRFAIL];
		word_hi[`PSW_HI_PGZ]   = power_not_good;
	end
	assign status_word = {word_hi, word_lo};

	////////////////////////////////////////////////////////////////////////////
	// command port; a write to the word falls through as a no-op

	assign mapped = (cmd_i == `PSW_CMD_WORD) || (cmd_i == `PSW_CMD_VOUT)
		|| (cmd_i == `PSW_CMD_IOUT) || (cmd_i == `PSW_CMD_MASK);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else if (ce_i) begin
			rvalid_q <= rd_i && mapped;
			if (rd_i) begin
				case (cmd_i)
					`PSW_CMD_WORD: rdata_q <= status_word;
					`PSW_CMD_VOUT: rdata_q <= {8'h00, vout_flags};
					`PSW_CMD_IOUT: rdata_q <= {8'h00, iout_flags};
					`PSW_CMD_MASK: rdata_q <= {vout_mask_q, iout_mask_q};
					default:       rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	// unmapped commands answer with a one-cycle refusal
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			nack_q <= 1'b0;
		end else if (ce_i) begin
			nack_q <= (rd_i || wr_i) && !mapped;
		end
	end

	assign rdata_o  = rdata_q;
	assign rvalid_o = rvalid_q;
	assign nack_o   = nack_q;

	assign alert_o = (|(vout_flags & ~vout_mask_q)) | (|(iout_flags & ~iout_mask_q))
		| pg_alert | ext_alert_i;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	word_read_data_a: assert property (
		ce_i && rd_i && cmd_i == `PSW_CMD_WORD |=> rdata_o == $past(status_word) && rvalid_o)
		else $error("status word read returned wrong data");
	off_bit_a: assert property (status_word[`PSW_LO_OFF] == !enable_i)
		else $error("off bit does not follow enable");
	vout_summary_a: assert property (status_word[8+`PSW_HI_VFW] == |vout_flags)
		else $error("voltage summary mismatch");
	iout_summary_a: assert property (
		status_word[8+`PSW_HI_CURRENT_SUMMARY] == (iout_flags[`PSW_IO_OCF] | iout_flags[`PSW_IO_OCW]))
		else $error("current summary mismatch");
	input_summary_a: assert property (status_word[8+`PSW_HI_INPUT] == |input_flags_i)
		else $error("input summary mismatch");
	word_write_ignored_a: assert property (
		ce_i && wr_i && cmd_i == `PSW_CMD_WORD && vout_set == 8'h00 && iout_set == 8'h00
		&& !loop_slave_i |=> $stable(vout_flags) && $stable(iout_flags))
		else $error("write to status word changed flags");
	pg_live_a: assert property (
		enable_i && !temp_cond_i && !low_vin_cond_i && !(|iout_cond_i)
		&& !vout_cond_i.overvoltage_fault_flag && !vout_cond_i.overvoltage_warning_flag
		&& !vout_cond_i.undervoltage_warning_flag && !vout_cond_i.undervoltage_fault_flag
		&& !vout_cond_i.turn_on_timeout_fault |-> !status_word[8+`PSW_HI_PGZ])
		else $error("power-not-good bit held with no live cause");
	pg_mask_reset_a: assert property ($fell(rst_i) |-> pg_mask_q)
		else $error("power-not-good mask not set after reset");
	pg_holdoff_a: assert property (
		!pg_armed && !ext_alert_i && (vout_flags & ~vout_mask_q) == 8'h00
		&& (iout_flags & ~iout_mask_q) == 8'h00 |-> !alert_o)
		else $error("power-not-good alert before first power good");
	ovf_set_a: assert property (
		ce_i && vout_evt_i.overvoltage_fault_flag && !loop_slave_i |=> vout_flags[`PSW_VO_OVF])
		else $error("overvoltage fault flag failed to set");
	vout_clear_a: assert property (
		ce_i && wr_vout && vout_set == 8'h00 && !loop_slave_i
		|=> vout_flags == ($past(vout_flags) & ~$past(wdata_i[7:0])))
		else $error("voltage flag clear wrong");
	loop_slave_a: assert property (ce_i && loop_slave_i |=> vout_flags == 8'h00)
		else $error("loop slave flags not held at zero");
	iout_fixed_a: assert property ((iout_flags & ~`PSW_IOUT_LIVE) == 8'h00)
		else $error("unused current flag bit set");
	alert_level_a: assert property (
		!ext_alert_i && !pg_alert && (vout_flags & ~vout_mask_q) == 8'h00
		&& (iout_flags & ~iout_mask_q) == 8'h00 |-> !alert_o)
		else $error("alert held with no unmasked flag");
	ovw_set_a: assert property (
		ce_i && vout_evt_i.overvoltage_warning_flag && !loop_slave_i |=> vout_flags[`PSW_VO_OVW])
		else $error("overvoltage warning flag failed to set");
	uvw_set_a: assert property (
		ce_i && vout_evt_i.undervoltage_warning_flag && !loop_slave_i |=> vout_flags[`PSW_VO_UVW])
		else $error("undervoltage warning flag failed to set");
	uvf_set_a: assert property (
		ce_i && vout_evt_i.undervoltage_fault_flag && !loop_slave_i |=> vout_flags[`PSW_VO_UVF])
		else $error("undervoltage fault flag failed to set");
	lim_set_a: assert property (
		ce_i && vout_evt_i.setpoint_limit_warning && !loop_slave_i |=> vout_flags[`PSW_VO_LIM])
		else $error("setpoint limit flag failed to set");
	ton_set_a: assert property (
		ce_i && vout_evt_i.turn_on_timeout_fault && !loop_slave_i |=> vout_flags[`PSW_VO_TON])
		else $error("turn-on timeout flag failed to set");
	ocf_set_a: assert property (
		ce_i && iout_evt_i.overcurrent_fault_flag |=> iout_flags[`PSW_IO_OCF])
		else $error("overcurrent fault flag failed to set");
	ocw_set_a: assert property (
		ce_i && iout_evt_i.overcurrent_warning_flag |=> iout_flags[`PSW_IO_OCW])
		else $error("overcurrent warning flag failed to set");
	mfr_summary_a: assert property (
		status_word[8+`PSW_HI_MFR]
		== (mfr_flags_i[`PSW_MF_OTFBG] || mfr_flags_i[`PSW_MF_ADDRFAIL]))
		else $error("maker-specific summary mismatch");
	pg_cause_a: assert property (
		!enable_i || temp_cond_i || low_vin_cond_i || (|iout_cond_i)
		|| vout_cond_i.overvoltage_fault_flag || vout_cond_i.undervoltage_fault_flag
		|| vout_cond_i.turn_on_timeout_fault |-> status_word[8+`PSW_HI_PGZ])
		else $error("power-not-good bit missing a live cause");
	catch_all_a: assert property (
		input_flags_i[`PSW_IN_LOWVIN] |-> status_word[`PSW_LO_OTH])
		else $error("catch-all bit ignores low input");
	mask_write_a: assert property (
		ce_i && wr_mask && wdata_i[7:0] == `PSW_CMD_VOUT |=> vout_mask_q == $past(wdata_i[15:8]))
		else $error("voltage alert mask not written");
	pg_arm_a: assert property (ce_i && power_good |=> pg_armed)
		else $error("power-not-good alert not armed after power good");

	ovf_set_clear_c: cover property (
		vout_flags[`PSW_VO_OVF] ##1 ce_i && wr_vout ##1 !vout_flags[`PSW_VO_OVF]);
	pg_armed_c: cover property (!pg_armed ##1 pg_armed);
	pg_alert_c: cover property (pg_alert && alert_o);
	unmapped_c: cover property (nack_o);
	frozen_event_c: cover property (!ce_i && (|vout_evt_i));
endmodule // psw_status

// File: test/psw_host.sv
`timescale 1ns/1ps
// host side of the status port; strobes move just after an edge
module psw_host (
	input  wire logic        mclk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic        rvalid_i,
	input  wire logic        nack_i,
	output logic      [7:0]  cmd_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [15:0] wdata_o
);
	initial begin
		cmd_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 16'h0000;
	end
	task automatic put(input logic [7:0] c, input logic [15:0] dat);
		@(posedge mclk_i);
		cmd_o <= c;
		wdata_o <= dat;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		// released data changes so a stale value cannot pass
		wdata_o <= ~dat;
		#1;
	endtask
	task automatic get(input logic [7:0] c, output logic [15:0] dat, output logic v, output logic n);
		@(posedge mclk_i);
		cmd_o <= c;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		#1;
		dat = rdata_i;
		v = rvalid_i;
		n = nack_i;
	endtask
endmodule // psw_host

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk_i, rst_i, ce_i, enable_i, loop_slave_i, temp_cond_i, low_vin_cond_i, ext_alert_i;
	logic [7:0] cmd, in_f, tmp_f, cml_f, mfr_f, vf, cf, vm, im, pre;
	logic [15:0] wdata, rdata, d;
	logic rd, wr, rvalid, nack, alert, v, n, pgm, armed;
	psw_pkg::psw_vout_evt_t vevt, vcond;
	psw_pkg::psw_iout_evt_t ievt, icond;
	int miscompares, check_count, cyc;

	psw_status u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_i(cmd), .rd_i(rd),
		.wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .nack_o(nack),
		.enable_i(enable_i), .loop_slave_i(loop_slave_i), .vout_evt_i(vevt),
		.iout_evt_i(ievt), .vout_cond_i(vcond), .iout_cond_i(icond),
		.temp_cond_i(temp_cond_i), .low_vin_cond_i(low_vin_cond_i), .input_flags_i(in_f),
		.temp_flags_i(tmp_f), .cml_flags_i(cml_f), .mfr_flags_i(mfr_f),
		.ext_alert_i(ext_alert_i), .alert_o(alert));
	psw_host u_host (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .nack_i(nack),
		.cmd_o(cmd), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	//////////////////////////////////////////////////////////////////////////////
	// setpoint field of the condition struct is not a power-good cause
	function automatic logic pnot();
		return !enable_i | (|vcond[5:2]) | vcond[0] | (|icond) | temp_cond_i | low_vin_cond_i;
	endfunction
	function automatic logic [15:0] word();
		logic [7:0] lo, hi;
		lo = {1'b0, !enable_i, vf[7], cf[7], 1'b0, |tmp_f, |cml_f,
			(|vf[6:2]) | cf[5] | in_f[3] | mfr_f[7] | mfr_f[4]};
		hi = {|vf, |cf, |in_f, mfr_f[7] | mfr_f[4], pnot(), 3'h0};
		return {hi, lo};
	endfunction
	function automatic logic exp_alert();
		return ext_alert_i | (|(vf & ~vm)) | (|(cf & ~im)) | (armed & pnot() & !pgm);
	endfunction
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		u_host.get(c, d, v, n);
		check("rdata", d, e);
		check("rvalid", {15'h0000, v}, 16'h0001);
	endtask
	task automatic achk();
		check("alert", {15'h0000, alert}, {15'h0000, exp_alert()});
	endtask
	task automatic pulse(input logic [5:0] ve, input logic [1:0] ie);
		@(posedge mclk_i);
		vevt <= ve;
		ievt <= ie;
		@(posedge mclk_i);
		vevt <= 6'h00;
		ievt <= 2'h0;
		#1;
		if (!loop_slave_i) vf = vf | {ve, 2'h0};
		cf = cf | {ie[1], 1'b0, ie[0], 5'h00};
	endtask
	task automatic clr(input logic [7:0] c, input logic [7:0] x);
		u_host.put(c, {8'h00, x});
		if (c == 8'h7A) vf = vf & ~x;
		else cf = cf & ~x;
	endtask
	task automatic msk(input logic [7:0] t, input logic [7:0] m);
		u_host.put(8'h1B, {m, t});
		if (t == 8'h7A) vm = m;
		else if (t == 8'h7B) im = m;
		else pgm = m[3];
	endtask
	task automatic env(input logic en, input logic [9:0] c, input logic x);
		@(posedge mclk_i);
		enable_i <= en;
		{vcond, icond, temp_cond_i, low_vin_cond_i} <= c;
		ext_alert_i <= x;
		in_f <= 8'($urandom);
		tmp_f <= 8'($urandom) & 8'($urandom);
		cml_f <= 8'($urandom) & 8'($urandom);
		mfr_f <= 8'($urandom) & 8'($urandom);
		repeat (3) @(posedge mclk_i);
		#1;
		if (!pnot()) armed = 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(88));
		{rst_i, ce_i, in_f} = {1'b1, 1'b1, 8'h08};
		{enable_i, loop_slave_i, temp_cond_i, low_vin_cond_i, ext_alert_i} = 5'h00;
		{tmp_f, cml_f, mfr_f, vevt, ievt, vcond, icond} = 40'h0;
		{vf, cf, vm, im, pgm, armed} = {32'h0, 1'b1, 1'b0};
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		rchk(8'h79, word());
		rchk(8'h7A, 16'h0000);
		rchk(8'h7B, 16'h0000);
		rchk(8'h1B, 16'h0000);
		achk();
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			pulse(6'(1 << i), 2'h0);
			rchk(8'h7A, {8'h00, vf});
			rchk(8'h79, word());
			achk();
		end
		pulse(6'h00, 2'h1);
		rchk(8'h7B, {8'h00, cf});
		pulse(6'h00, 2'h2);
		rchk(8'h7B, {8'h00, cf});
		rchk(8'h79, word());
		// clear one at a time, summary follows
		for (int i = 0; i < 8; i++) begin
			clr(8'h7A, 8'(1 << i));
			rchk(8'h79, word());
		end
		u_host.put(8'h79, 16'hFFFF);
		rchk(8'h79, word());
		clr(8'h7B, 8'h80);
		rchk(8'h7B, {8'h00, cf});
		clr(8'h7B, 8'h7F);
		rchk(8'h79, word());
		achk();
		u_host.get(8'h55, d, v, n);
		check("nack", {15'h0000, n}, 16'h0001);
		check("bad rdata", d, 16'h0000);
		$display("test flags done");
		pulse(6'h20, 2'h2);
		msk(8'h7A, 8'h80);
		achk();
		msk(8'h7B, 8'h80);
		achk();
		rchk(8'h1B, {vm, im});
		msk(8'h7A, 8'h00);
		msk(8'h7B, 8'h7F);
		achk();
		clr(8'h7A, 8'hFF);
		clr(8'h7B, 8'hFF);
		achk();
		$display("test masks done");
		// frozen clock enable drops events and clears alike
		@(posedge mclk_i);
		ce_i <= 1'b0;
		fork
			pulse(6'h3F, 2'h3);
			u_host.put(8'h7A, 16'h00FF);
		join
		@(posedge mclk_i);
		ce_i <= 1'b1;
		{vf, cf} = 16'h0000;
		rchk(8'h7A, 16'h0000);
		rchk(8'h7B, 16'h0000);
		achk();
		$display("test clock enable done");
		// loop slave holds voltage flags at zero
		pulse(6'h3F, 2'h0);
		@(posedge mclk_i);
		loop_slave_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		vf = 8'h00;
		rchk(8'h7A, 16'h0000);
		pulse(6'h3F, 2'h0);
		rchk(8'h79, word());
		loop_slave_i <= 1'b0;
		$display("test loop slave done");
		msk(8'h79, 8'h00);
		env(1'b0, 10'h000, 1'b0);
		achk();
		env(1'b1, 10'h000, 1'b0);
		achk();
		for (int k = 0; k < 10; k++) begin
			env(1'b1, 10'(1 << k), 1'b0);
			rchk(8'h79, word());
			achk();
			env(1'b1, 10'h000, 1'b0);
			achk();
		end
		env(1'b0, 10'h000, 1'b0);
		achk();
		// mid-run reset must bring the power-good mask back to 1
		@(posedge mclk_i);
		rst_i <= 1'b1;
		@(posedge mclk_i);
		rst_i <= 1'b0;
		{vf, cf, vm, im, pgm, armed} = {32'h0, 1'b1, 1'b0};
		rchk(8'h79, word());
		env(1'b1, 10'h000, 1'b0);
		env(1'b0, 10'h000, 1'b0);
		achk();
		msk(8'h79, 8'h08);
		achk();
		$display("test power good done");
		// random traffic, set beats clear in one cycle
		for (int r = 0; r < 40; r++) begin
			env(1'($urandom), 10'($urandom) & 10'($urandom) & 10'($urandom), 1'($urandom));
			pre = vf;
			d = 16'($urandom);
			fork
				pulse(d[15:10], d[9:8]);
				u_host.put(8'h7A, {8'h00, d[7:0]});
			join
			vf = (pre & ~d[7:0] & 8'hFC) | {d[15:10], 2'h0};
			if (r[0]) clr(8'h7B, 8'($urandom));
			if (r[2]) msk(8'h7A, 8'($urandom));
			rchk(8'h7A, {8'h00, vf});
			rchk(8'h7B, {8'h00, cf});
			rchk(8'h79, word());
			achk();
		end
		$display("test random done");
		tally_and_finish();
	end
endmodule // testbench
